// [cle_pkg.sv]
// Package: encodings and carriers for the coherent-lite request encoder
package cle_pkg;

	// ------------------------------------------------------------
	// Field widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 32;
	localparam int ID_W = 4;
	localparam int LEN_W = 8;
	localparam int OP_W = 3;
	localparam int SNOOP_W = 4;
	localparam int DOM_W = 2;
	localparam int NUM_CH = 2;
	localparam int CH_RD = 0;
	localparam int CH_WR = 1;

	// ------------------------------------------------------------
	// Domain codes
	// ------------------------------------------------------------
	localparam logic [1:0] DOM_NONSH = 2'h0;
	localparam logic [1:0] DOM_INNER = 2'h1;
	localparam logic [1:0] DOM_OUTER = 2'h2;
	localparam logic [1:0] DOM_SYSTEM = 2'h3;

	// ------------------------------------------------------------
	// Snoop codes
	// ------------------------------------------------------------
	localparam logic [3:0] SNP_ZERO = 4'h0;
	localparam logic [3:0] SNP_CLEAN_SHARED = 4'h8;
	localparam logic [3:0] SNP_CLEAN_INVALID = 4'h9;
	localparam logic [3:0] SNP_MAKE_INVALID = 4'hD;
	localparam logic [3:0] SNP_LINE_UNIQUE = 4'h1;
	localparam logic BAR_OFF = 1'h0;
	localparam logic BAR_ON = 1'h1;

	// ------------------------------------------------------------
	// Request kinds
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		RD_NOSNOOP = 3'h0,
		RD_ONCE = 3'h1,
		RD_CLEAN_SHARED = 3'h2,
		RD_CLEAN_INVALID = 3'h3,
		RD_MAKE_INVALID = 3'h4,
		RD_BARRIER = 3'h5
	} cle_rd_op_type;

	typedef enum logic [2:0] {
		WR_NOSNOOP = 3'h0,
		WR_UNIQUE = 3'h1,
		WR_LINE_UNIQUE = 3'h2,
		WR_BARRIER = 3'h5
	} cle_wr_op_type;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [ID_W-1:0] id;
		logic [LEN_W-1:0] len;
		logic [OP_W-1:0] op;
		logic [DOM_W-1:0] domain;
	} cle_req_type;

	// Write channel uses snoop[2:0]; snoop[3] is always zero there
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [ID_W-1:0] id;
		logic [LEN_W-1:0] len;
		logic [SNOOP_W-1:0] snoop;
		logic bar;
		logic [DOM_W-1:0] domain;
	} cle_ax_type;

endpackage : cle_pkg

// [cle_lite_check.sv]
// Module: maps a request kind and domain to snoop and barrier, with legality
`timescale 1ns/1ps

module cle_lite_check #(
	parameter bit IS_WRITE = 1'b0
) (
	input wire logic [cle_pkg::OP_W-1:0] op,
	input wire logic [cle_pkg::DOM_W-1:0] domain,
	output logic [cle_pkg::SNOOP_W-1:0] snoop,
	output logic bar,
	output logic legal
);
	import cle_pkg::*;

	logic nonsh;
	logic shar;

	assign nonsh = (domain == DOM_NONSH) || (domain == DOM_SYSTEM);
	assign shar = (domain == DOM_INNER) || (domain == DOM_OUTER);

	always_comb begin
		snoop = SNP_ZERO;
		bar = BAR_OFF;
		legal = 1'b0;
		if (!IS_WRITE) begin
			unique case (op)
				RD_NOSNOOP: legal = nonsh; // R1 R2
				RD_ONCE: legal = shar; // R2
				RD_CLEAN_SHARED: begin
					snoop = SNP_CLEAN_SHARED; // R3
					legal = domain != DOM_SYSTEM;
				end
				RD_CLEAN_INVALID: begin
					snoop = SNP_CLEAN_INVALID; // R3
					legal = domain != DOM_SYSTEM;
				end
				RD_MAKE_INVALID: begin
					snoop = SNP_MAKE_INVALID; // R3
					legal = domain != DOM_SYSTEM;
				end
				RD_BARRIER: begin
					bar = BAR_ON; // R5
					legal = 1'b1;
				end
				default: legal = 1'b0; // R1
			endcase
		end else begin
			unique case (op)
				WR_NOSNOOP: legal = nonsh; // R1 R4
				WR_UNIQUE: legal = shar; // R4
				WR_LINE_UNIQUE: begin
					snoop = SNP_LINE_UNIQUE; // R4
					legal = shar;
				end
				WR_BARRIER: begin
					bar = BAR_ON; // R5
					legal = 1'b1;
				end
				default: legal = 1'b0; // R1
			endcase
		end
	end

endmodule : cle_lite_check

// [cle_lite_encoder.sv]
// Module: coherent-lite master request encoder for the AR and AW channels
`timescale 1ns/1ps

// Summary of operation
// R1 - All non-shareable; only listed shareable encodings
// R2 - Read no-snoop and read-once encodings
// R3 - Read cache maintenance snoop codes, domain
// R4 - Write no-snoop, unique, line-unique encodings
// R5 - Barrier: bar high, snoop zero, any domain
// R6 - Plain AXI4 plus address-channel coherency fields
// R7 - No snoop channels, acknowledges, extra response
// R8 - Illegal triples flagged and never issued
module cle_lite_encoder (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic rd_req_valid,
	input wire cle_pkg::cle_req_type rd_req,
	output logic rd_req_ready,
	output logic rd_req_err,
	input wire logic wr_req_valid,
	input wire cle_pkg::cle_req_type wr_req,
	output logic wr_req_ready,
	output logic wr_req_err,
	output logic ar_valid,
	output cle_pkg::cle_ax_type ar,
	input wire logic ar_ready,
	output logic aw_valid,
	output cle_pkg::cle_ax_type aw,
	input wire logic aw_ready
);
	import cle_pkg::*;

	// ------------------------------------------------------------
	// Per-channel views
	// ------------------------------------------------------------
	logic req_valid [NUM_CH];
	cle_req_type req [NUM_CH];
	logic ax_ready [NUM_CH];
	logic [SNOOP_W-1:0] chk_snoop [NUM_CH];
	logic chk_bar [NUM_CH];
	logic chk_legal [NUM_CH];
	logic take [NUM_CH];
	logic valid_r [NUM_CH];
	logic valid_nxt [NUM_CH];
	logic ready_r [NUM_CH];
	logic err_r [NUM_CH];
	cle_ax_type ax_r [NUM_CH];
	logic [OP_W-1:0] op_r [NUM_CH];

	assign req_valid[CH_RD] = rd_req_valid;
	assign req_valid[CH_WR] = wr_req_valid;
	assign req[CH_RD] = rd_req;
	assign req[CH_WR] = wr_req;
	assign ax_ready[CH_RD] = ar_ready;
	assign ax_ready[CH_WR] = aw_ready;

	// ------------------------------------------------------------
	// Channel slots
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			cle_lite_check #(
				.IS_WRITE(gi == CH_WR)
			) u_check (
				.op(req[gi].op),
				.domain(req[gi].domain),
				.snoop(chk_snoop[gi]),
				.bar(chk_bar[gi]),
				.legal(chk_legal[gi])
			);

			// Slot takes a request only while empty
			assign take[gi] = req_valid[gi] && ready_r[gi];

			always_comb begin
				valid_nxt[gi] = valid_r[gi];
				if (take[gi] && chk_legal[gi]) begin
					valid_nxt[gi] = 1'b1; // R8
				end else if (valid_r[gi] && ax_ready[gi]) begin
					valid_nxt[gi] = 1'b0; // R6
				end
			end

			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					valid_r[gi] <= 1'b0;
					ready_r[gi] <= 1'b0;
				end else begin
					valid_r[gi] <= valid_nxt[gi];
					ready_r[gi] <= !valid_nxt[gi];
				end
			end

			// Illegal request is consumed, dropped and flagged
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					err_r[gi] <= 1'b0;
				end else begin
					err_r[gi] <= take[gi] && !chk_legal[gi]; // R8
				end
			end

			// Address payload, held until the handshake
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					ax_r[gi] <= '0;
					op_r[gi] <= '0;
				end else if (take[gi] && chk_legal[gi]) begin
					ax_r[gi].addr <= req[gi].addr; // R6
					ax_r[gi].id <= req[gi].id;
					ax_r[gi].len <= req[gi].len;
					ax_r[gi].snoop <= chk_snoop[gi]; // R2 R3 R4 R5
					ax_r[gi].bar <= chk_bar[gi]; // R5
					ax_r[gi].domain <= req[gi].domain; // R1
					op_r[gi] <= req[gi].op;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Only AR and AW are driven; no snoop or acknowledge path exists
	assign ar_valid = valid_r[CH_RD]; // R7
	assign ar = ax_r[CH_RD];
	assign aw_valid = valid_r[CH_WR]; // R7
	assign aw = ax_r[CH_WR];
	assign rd_req_ready = ready_r[CH_RD];
	assign wr_req_ready = ready_r[CH_WR];
	assign rd_req_err = err_r[CH_RD];
	assign wr_req_err = err_r[CH_WR];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	function automatic logic rd_ok(cle_ax_type a);
		if (a.bar) begin
			return a.snoop == SNP_ZERO;
		end
		unique case (a.snoop)
			SNP_ZERO: return 1'b1;
			SNP_CLEAN_SHARED,
			SNP_CLEAN_INVALID,
			SNP_MAKE_INVALID: return a.domain != DOM_SYSTEM;
			default: return 1'b0;
		endcase
	endfunction : rd_ok

	function automatic logic wr_ok(cle_ax_type a);
		logic sh;
		sh = (a.domain == DOM_INNER) || (a.domain == DOM_OUTER);
		if (a.bar) begin
			return a.snoop == SNP_ZERO;
		end
		unique case (a.snoop)
			SNP_ZERO: return 1'b1;
			SNP_LINE_UNIQUE: return sh;
			default: return 1'b0;
		endcase
	endfunction : wr_ok

	a_rd_nosnoop_enc: assert property ( // R2
		ar_valid && op_r[CH_RD] == RD_NOSNOOP |->
		ar.snoop == SNP_ZERO && !ar.bar &&
		(ar.domain == DOM_NONSH || ar.domain == DOM_SYSTEM))
		else $error("read no-snoop encoding wrong");

	a_rd_once_enc: assert property ( // R2
		ar_valid && op_r[CH_RD] == RD_ONCE |->
		ar.snoop == SNP_ZERO && !ar.bar &&
		(ar.domain == DOM_INNER || ar.domain == DOM_OUTER))
		else $error("read-once encoding wrong");

	a_rd_maint_enc: assert property ( // R3
		ar_valid && op_r[CH_RD] == RD_CLEAN_INVALID |->
		ar.snoop == SNP_CLEAN_INVALID && !ar.bar &&
		ar.domain != DOM_SYSTEM)
		else $error("clean-invalid encoding wrong");

	a_rd_clean_enc: assert property ( // R3
		ar_valid && op_r[CH_RD] == RD_CLEAN_SHARED |->
		ar.snoop == SNP_CLEAN_SHARED && !ar.bar &&
		ar.domain != DOM_SYSTEM)
		else $error("clean-shared encoding wrong");

	a_rd_makeinv_enc: assert property ( // R3
		ar_valid && op_r[CH_RD] == RD_MAKE_INVALID |->
		ar.snoop == SNP_MAKE_INVALID && !ar.bar &&
		ar.domain != DOM_SYSTEM)
		else $error("make-invalid encoding wrong");

	a_wr_line_enc: assert property ( // R4
		aw_valid && op_r[CH_WR] == WR_LINE_UNIQUE |->
		aw.snoop == SNP_LINE_UNIQUE && !aw.bar &&
		(aw.domain == DOM_INNER || aw.domain == DOM_OUTER))
		else $error("line-unique encoding wrong");

	a_bar_snoop_zero: assert property ( // R5
		(ar_valid && ar.bar) || (aw_valid && aw.bar) |->
		(!ar.bar || ar.snoop == SNP_ZERO) &&
		(!aw.bar || aw.snoop == SNP_ZERO))
		else $error("barrier with nonzero snoop");

	a_legal_triple: assert property ( // R1 R8
		(ar_valid |-> rd_ok(ar)) and (aw_valid |-> wr_ok(aw)))
		else $error("illegal triple issued");

	a_illegal_flagged: assert property ( // R8
		rd_req_valid && rd_req_ready && !chk_legal[CH_RD] |=>
		rd_req_err && !ar_valid ##1
		(!rd_req_err || $past(rd_req_valid && rd_req_ready)))
		else $error("illegal read not flagged");

	a_aw_hold_stable: assert property ( // R6
		aw_valid && !aw_ready |=> aw_valid && $stable(aw))
		else $error("write address dropped before handshake");

	a_ar_issue_lat: assert property ( // R6
		rd_req_valid && rd_req_ready && chk_legal[CH_RD] |=>
		ar_valid && !rd_req_ready && ar.addr == $past(rd_req.addr))
		else $error("read request not issued next cycle");

	c_rd_barrier: cover property (ar_valid && ar_ready && ar.bar);
	c_wr_line: cover property (aw_valid && aw_ready &&
		aw.snoop == SNP_LINE_UNIQUE);
	c_rd_illegal: cover property (rd_req_err);
	c_ar_stall: cover property (ar_valid && !ar_ready ##1
		ar_valid && ar_ready);

endmodule : cle_lite_encoder

// [cle_ic_model.sv]
// Interconnect model: AR and AW slave with prompt or stalling ready
`timescale 1ns/1ps

module cle_ic_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic slow,
	input wire logic ar_valid,
	input wire cle_pkg::cle_ax_type ar,
	input wire logic aw_valid,
	input wire cle_pkg::cle_ax_type aw,
	output logic ar_ready,
	output logic aw_ready,
	output cle_pkg::cle_ax_type ar_got,
	output cle_pkg::cle_ax_type aw_got,
	output int ar_cnt,
	output int aw_cnt
);
	import cle_pkg::*;

	// ------------------------------------------------------------
	// Address channels only, no snoop or acknowledge path
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ar_ready <= 1'b0;
			aw_ready <= 1'b0;
		end else begin
			ar_ready <= slow ? ~ar_ready : 1'b1;
			aw_ready <= slow ? ~aw_ready : 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ar_cnt <= 0;
			aw_cnt <= 0;
		end else begin
			if (ar_valid && ar_ready) begin
				ar_got <= ar;
				ar_cnt <= ar_cnt + 1;
			end
			if (aw_valid && aw_ready) begin
				aw_got <= aw;
				aw_cnt <= aw_cnt + 1;
			end
		end
	end

endmodule : cle_ic_model

// [test_cle_lite_encoder.sv]
// Testbench: encoding sweeps, stalls and reset of the lite encoder
`timescale 1ns/1ps

module test_cle_lite_encoder;
	import cle_pkg::*;

	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic slow = 1'b0;
	logic rd_req_valid = 1'b0;
	logic wr_req_valid = 1'b0;
	cle_req_type rd_req = '0;
	cle_req_type wr_req = '0;
	logic rd_req_ready, rd_req_err, wr_req_ready, wr_req_err;
	logic ar_valid, aw_valid, ar_ready, aw_ready;
	cle_ax_type ar, aw, ar_got, aw_got;
	int ar_cnt, aw_cnt;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;

	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	cle_lite_encoder dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
		.rd_req_valid(rd_req_valid), .rd_req(rd_req),
		.rd_req_ready(rd_req_ready), .rd_req_err(rd_req_err),
		.wr_req_valid(wr_req_valid), .wr_req(wr_req),
		.wr_req_ready(wr_req_ready), .wr_req_err(wr_req_err),
		.ar_valid(ar_valid), .ar(ar), .ar_ready(ar_ready),
		.aw_valid(aw_valid), .aw(aw), .aw_ready(aw_ready));

	cle_ic_model ic_u (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
		.ar_valid(ar_valid), .ar(ar), .aw_valid(aw_valid), .aw(aw),
		.ar_ready(ar_ready), .aw_ready(aw_ready), .ar_got(ar_got),
		.aw_got(aw_got), .ar_cnt(ar_cnt), .aw_cnt(aw_cnt));

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// Expected {legal, bar, snoop} from kind and domain
	function automatic logic [5:0] exp_of(input bit wr, input logic [2:0] op,
		input logic [1:0] d);
		logic sh;
		sh = (d == DOM_INNER) || (d == DOM_OUTER);
		case (op)
			3'h0: return {~sh, BAR_OFF, SNP_ZERO};
			3'h1: return {sh, BAR_OFF, SNP_ZERO};
			3'h2: return wr ? {sh, BAR_OFF, SNP_LINE_UNIQUE}
				: {d != DOM_SYSTEM, BAR_OFF, SNP_CLEAN_SHARED};
			3'h3: return {~wr && d != DOM_SYSTEM, BAR_OFF, SNP_CLEAN_INVALID};
			3'h4: return {~wr && d != DOM_SYSTEM, BAR_OFF, SNP_MAKE_INVALID};
			3'h5: return {1'b1, BAR_ON, SNP_ZERO};
			default: return 6'h00;
		endcase
	endfunction : exp_of

	task automatic issue(input bit wr, input logic [2:0] op,
		input logic [1:0] d, input logic [31:0] a);
		cle_req_type q;
		cle_ax_type g;
		logic [5:0] e;
		int n0;
		int k;
		q = '{addr: a, id: a[3:0], len: a[11:4], op: op, domain: d};
		e = exp_of(wr, op, d);
		n0 = wr ? aw_cnt : ar_cnt;
		if (wr) begin
			wr_req = q;
			wr_req_valid = 1'b1;
		end else begin
			rd_req = q;
			rd_req_valid = 1'b1;
		end
		k = 0;
		while ((wr ? wr_req_ready : rd_req_ready) !== 1'b1 && k < 50) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		@(posedge ref_clk);
		#1;
		if (wr) wr_req_valid = 1'b0;
		else rd_req_valid = 1'b0;
		chk("req_err", !e[5], wr ? wr_req_err : rd_req_err);
		chk("ax_valid", e[5], wr ? aw_valid : ar_valid);
		chk("req_ready", !e[5], wr ? wr_req_ready : rd_req_ready);
		k = 0;
		while ((wr ? aw_cnt : ar_cnt) == n0 && k < (e[5] ? 20 : 3)) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		chk("issued", n0 + e[5], wr ? aw_cnt : ar_cnt);
		g = wr ? aw_got : ar_got;
		if (e[5]) begin
			chk("snoop", e[3:0], g.snoop);
			chk("bar", e[4], g.bar);
			chk("domain", d, g.domain);
			chk("addr", a, g.addr);
			chk("id_len", {q.id, q.len}, {g.id, g.len});
		end
	endtask : issue

	task automatic sweep(input bit wr);
		for (int op = 0; op < 8; op++)
			for (int d = 0; d < 4; d++)
				issue(wr, op[2:0], d[1:0], 32'hA5C3_0000 + (op << 8) + d);
	endtask : sweep

	task automatic test_read_sweep();
		sweep(1'b0);
	endtask : test_read_sweep

	task automatic test_write_sweep();
		sweep(1'b1);
	endtask : test_write_sweep

	task automatic test_both_slow();
		slow = 1'b1;
		fork
			sweep(1'b0);
			sweep(1'b1);
		join
		slow = 1'b0;
	endtask : test_both_slow

	task automatic test_reset();
		rd_req_valid = 1'b1;
		rd_req = '{addr: 32'h0000_1000, id: 4'h3, len: 8'h00,
			op: RD_ONCE, domain: DOM_INNER};
		@(posedge ref_clk);
		#1;
		reset_n = 1'b0;
		rd_req_valid = 1'b0;
		#1;
		chk("rst_ar_valid", 1'b0, ar_valid);
		chk("rst_ready", 2'h0, {rd_req_ready, wr_req_ready});
		@(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		@(posedge ref_clk);
		#1;
		chk("ready_after_rst", 2'h3, {rd_req_ready, wr_req_ready});
		issue(1'b0, RD_CLEAN_INVALID, DOM_NONSH, 32'h0000_2040);
	endtask : test_reset

	initial begin
		repeat (12) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		@(posedge ref_clk);
		#1;
		test_read_sweep();
		test_write_sweep();
		test_both_slow();
		test_reset();
		print_verdict();
	end

endmodule : test_cle_lite_encoder
